/* logic/viu_regs.svh */
`ifndef VIU_REGS_SVH
`define VIU_REGS_SVH

// ==========================================================
// register offsets
`define VIU_CFG_OFS        8'h00
`define VIU_STAT_OFS       8'h04

// ==========================================================
// control register fields
`define VIU_CFG_FMT1_LSB   0
`define VIU_CFG_FMT2_LSB   4
`define VIU_CFG_EDGE1_LSB  8
`define VIU_CFG_EDGE2_LSB  10
`define VIU_CFG_GANG_RISE  12
`define VIU_CFG_MUX_PORT   13
`define VIU_CFG_MASK       32'h0000_3fff
`define VIU_CFG_RESET      32'h0000_0044

// ==========================================================
// status register fields
`define VIU_STAT_FIELD     0
`define VIU_STAT_VBLANK    1
`define VIU_STAT_HTYPE     2
`define VIU_STAT_MISMATCH  3
`define VIU_STAT_BADFMT    4

// ==========================================================
// format codes and edge selections
`define VIU_FMT_MUX_YCC    4'h4
`define VIU_FMT_RGB24      4'h5
`define VIU_FMT_YCC16      4'h6
`define VIU_FMT_YCC24      4'h7
`define VIU_FMT_LVDS_OE    4'h8
`define VIU_FMT_LVDS_NORM  4'h9
`define VIU_EDGE_RISE      2'h0
`define VIU_EDGE_FALL      2'h1

// ==========================================================
// embedded timing reference
`define VIU_CODE_ONES      8'hff
`define VIU_CODE_ZERO      8'h00
`define VIU_CODE_FIELD     6
`define VIU_CODE_VBLANK    5
`define VIU_CODE_HTYPE     4

`endif

/* logic/viu_pkg.sv */
`default_nettype none

package viu_pkg;
  // byte slot within a group, one-hot
  typedef enum logic [3:0] {
    VIU_SLOT_CB = 4'b0001,
    VIU_SLOT_Y0 = 4'b0010,
    VIU_SLOT_CR = 4'b0100,
    VIU_SLOT_Y1 = 4'b1000
  } viu_slot_type;

  // which capture path the format selectors choose
  typedef enum logic [2:0] {
    VIU_KIND_NONE = 3'b001,
    VIU_KIND_MUX  = 3'b010,
    VIU_KIND_GANG = 3'b100
  } viu_kind_type;
endpackage

`default_nettype wire

/* logic/viu_pin_sync.sv */
`default_nettype none
`include "viu_regs.svh"

module viu_pin_sync
  import viu_pkg::*;
(
  input  wire logic        mclk,      // system clock
  input  wire logic        reset,     // async reset, active high
  input  wire logic        pin_clk,   // pixel clock pin
  input  wire logic [11:0] pin_bus,   // pixel data pins
  input  wire logic        pin_hs,    // horizontal sync pin
  input  wire logic        pin_vs,    // vertical sync pin
  input  wire logic        pin_de,    // data enable pin
  input  wire logic [1:0]  edge_sel,  // rise, fall or both
  output logic      [11:0] bus_q,     // captured data
  output logic             hs_q,      // synced hsync
  output logic             vs_q,      // synced vsync
  output logic             de_q,      // synced data enable
  output logic             latch_q,   // one-cycle capture pulse
  output logic             hs_lead_q  // one-cycle hsync leading edge
);

  logic [15:0] s1_reg;
  logic [15:0] s2_reg;
  logic [1:0]  s3_reg;
  wire  logic  clk_rise;
  wire  logic  clk_fall;
  wire  logic  take;

  // ==========================================================
  // two-stage synchroniser; third stage only feeds edge detect
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_reg <= 16'h0000;
      s2_reg <= 16'h0000;
      s3_reg <= 2'h0;
    end else begin
      s1_reg <= {pin_clk, pin_hs, pin_vs, pin_de, pin_bus};
      s2_reg <= s1_reg;
      s3_reg <= {s2_reg[15], s2_reg[14]};
    end
  end

  // edge picks; data sampled alongside the synced clock
  assign clk_rise = s2_reg[15] & ~s3_reg[1];
  assign clk_fall = ~s2_reg[15] & s3_reg[1];
  assign take     = (edge_sel == `VIU_EDGE_RISE) ? clk_rise :
                    (edge_sel == `VIU_EDGE_FALL) ? clk_fall :
                    (clk_rise | clk_fall);

  // ==========================================================
  // registered outputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus_q     <= 12'h000;
      hs_q      <= 1'b0;
      vs_q      <= 1'b0;
      de_q      <= 1'b0;
      latch_q   <= 1'b0;
      hs_lead_q <= 1'b0;
    end else begin
      bus_q     <= s2_reg[11:0];
      hs_q      <= s2_reg[14];
      vs_q      <= s2_reg[13];
      de_q      <= s2_reg[12];
      latch_q   <= take;
      hs_lead_q <= s2_reg[14] & ~s3_reg[0];
    end
  end

endmodule // viu_pin_sync

`default_nettype wire

/* logic/viu_unpack.sv */
// Contract
// - format 4 lanes carry Cb, Y, Cr, Y on the low eight bits.
// - format 4 decodes embedded sync; code starts in a Cb slot.
// - timing reference is ones, zero, zero, then status byte; format 7 decode does not check the second zero.
// - status bit 6 is field: one means second field.
// - status bit 5 is vertical blanking.
// - status bit 4 one means end of active video, zero start.
// - status bits 7 and 3..0 are ignored.
// - 24-bit formats capture once per pixel on one edge, default falling.
// - codes 5..9 decode as RGB, YCrCb16, YCrCb24, LVDS odd/even, LVDS.
// - 16-bit YCrCb: Cb with Y first clock, Cr with next Y after.
// - format 5 RGB and formats 6,7 luma placement on the ports.
// - format 6 chroma spans port 1 low and port 2 high nibbles.
// - format 7 carries own Cr and Cb per pixel.
// - formats 6 and 7 decode embedded sync aligned to a Cb slot.
// - multiplexed words pair into pixels from the hsync leading edge.
// - multiplexed capture edge is rising, falling or both per port.
`default_nettype none
`include "viu_regs.svh"

module viu_unpack
  import viu_pkg::*;
(
  input  wire logic        mclk,               // system clock, 250 MHz
  input  wire logic        reset,              // async reset, active high
  input  wire logic [7:0]  reg_addr,           // register byte address
  input  wire logic [31:0] reg_wdata,          // register write data
  input  wire logic        reg_wr,             // write strobe
  input  wire logic        reg_rd,             // read strobe
  output logic      [31:0] reg_rdata,          // read data, cycle after strobe
  input  wire logic [11:0] port1_pixel_bus,    // port 1 data pins
  input  wire logic        port1_hsync,        // port 1 hsync
  input  wire logic        port1_vsync,        // port 1 vsync
  input  wire logic        port1_data_enable,  // port 1 data enable
  input  wire logic        port1_pixel_clock,  // port 1 pixel clock
  input  wire logic [11:0] port2_pixel_bus,    // port 2 data pins
  input  wire logic        port2_hsync,        // port 2 hsync
  input  wire logic        port2_vsync,        // port 2 vsync
  input  wire logic        port2_data_enable,  // port 2 data enable
  input  wire logic        port2_pixel_clock,  // port 2 pixel clock
  output logic             pix_valid,          // one-cycle pixel strobe
  output logic      [23:0] pix_data,           // {Y,Cr,Cb} or {R,G,B}
  output logic             pix_hsync,          // hsync of active port
  output logic             pix_vsync,          // vsync of active port
  output logic             pix_de,             // data enable of active port
  output logic             pix_field,          // decoded field flag
  output logic             pix_vblank,         // decoded vertical blanking
  output logic             sync_eav,           // pulse: end-of-active code
  output logic             sync_sav            // pulse: start-of-active code
);

  // ==========================================================
  // state
  logic [31:0]  cfg_reg;
  logic         field_reg, vblank_reg, htype_reg;
  viu_slot_type slot_reg, slot_next, slot_cur;
  logic [7:0]   a_reg, y0_reg, c_reg;
  logic         pend_reg;
  logic [23:0]  pend_data_reg;

  wire logic [11:0] p1_bus, p2_bus;
  wire logic        p1_hs, p1_vs, p1_de, p1_latch, p1_lead;
  wire logic        p2_hs, p2_vs, p2_de, p2_latch, p2_lead;

  // ==========================================================
  // helpers
  function automatic viu_kind_type viu_kind(input logic [3:0] fmt);
    if (fmt == `VIU_FMT_MUX_YCC)
      return VIU_KIND_MUX;
    else if (fmt >= `VIU_FMT_RGB24 && fmt <= `VIU_FMT_LVDS_NORM)
      return VIU_KIND_GANG;
    else
      return VIU_KIND_NONE;
  endfunction

  // slot order: Cb,Y,Cr,Y for bytes; Cb/Cr pair per 24-bit capture
  function automatic viu_slot_type viu_advance(input viu_slot_type s,
                                               input logic byte_mode);
    case (s)
      VIU_SLOT_CB: return byte_mode ? VIU_SLOT_Y0 : VIU_SLOT_CR;
      VIU_SLOT_Y0: return VIU_SLOT_CR;
      VIU_SLOT_CR: return byte_mode ? VIU_SLOT_Y1 : VIU_SLOT_CB;
      VIU_SLOT_Y1: return VIU_SLOT_CB;
      default:     return VIU_SLOT_CB;
    endcase
  endfunction

  // ==========================================================
  // configuration decode
  wire logic [3:0]   fmt1     = cfg_reg[`VIU_CFG_FMT1_LSB +: 4];
  wire logic [3:0]   fmt2     = cfg_reg[`VIU_CFG_FMT2_LSB +: 4];
  wire logic         mux_sel  = cfg_reg[`VIU_CFG_MUX_PORT];
  wire logic [3:0]   mux_fmt  = mux_sel ? fmt2 : fmt1;
  wire logic         mismatch = (viu_kind(fmt1) == VIU_KIND_GANG) && (fmt1 != fmt2);
  wire viu_kind_type kind     = (viu_kind(mux_fmt) == VIU_KIND_MUX) ? VIU_KIND_MUX :
                                (viu_kind(fmt1) == VIU_KIND_GANG && !mismatch) ?
                                VIU_KIND_GANG : VIU_KIND_NONE;
  wire logic         is_mux   = (kind == VIU_KIND_MUX);
  wire logic         is_gang  = (kind == VIU_KIND_GANG);
  wire logic         fmt6     = (fmt1 == `VIU_FMT_YCC16);
  // 6 and 7 pair up pixels; 5, 8 and 9 pass the 24 bits per pixel
  wire logic         is_pair  = is_gang && (fmt6 || fmt1 == `VIU_FMT_YCC24);
  wire logic         single   = is_gang && !is_pair;
  // ganged capture uses one edge, falling unless asked otherwise
  wire logic [1:0]   gang_edge = {1'b0, ~cfg_reg[`VIU_CFG_GANG_RISE]};
  wire logic [1:0]   edge1 = is_gang ? gang_edge : cfg_reg[`VIU_CFG_EDGE1_LSB +: 2];
  wire logic [1:0]   edge2 = is_gang ? gang_edge : cfg_reg[`VIU_CFG_EDGE2_LSB +: 2];

  // ==========================================================
  // pin capture per port
  viu_pin_sync u_port1 (
    .mclk      (mclk),
    .reset     (reset),
    .pin_clk   (port1_pixel_clock),
    .pin_bus   (port1_pixel_bus),
    .pin_hs    (port1_hsync),
    .pin_vs    (port1_vsync),
    .pin_de    (port1_data_enable),
    .edge_sel  (edge1),
    .bus_q     (p1_bus),
    .hs_q      (p1_hs),
    .vs_q      (p1_vs),
    .de_q      (p1_de),
    .latch_q   (p1_latch),
    .hs_lead_q (p1_lead)
  );

  viu_pin_sync u_port2 (
    .mclk      (mclk),
    .reset     (reset),
    .pin_clk   (port2_pixel_clock),
    .pin_bus   (port2_pixel_bus),
    .pin_hs    (port2_hsync),
    .pin_vs    (port2_vsync),
    .pin_de    (port2_data_enable),
    .edge_sel  (edge2),
    .bus_q     (p2_bus),
    .hs_q      (p2_hs),
    .vs_q      (p2_vs),
    .de_q      (p2_de),
    .latch_q   (p2_latch),
    .hs_lead_q (p2_lead)
  );

  // ==========================================================
  // stream selection; ganged mode trusts port 1 timing for both ports
  wire logic       use2   = is_mux && mux_sel;
  wire logic [7:0] mbyte  = use2 ? p2_bus[7:0] : p1_bus[7:0];
  wire logic       cap    = is_mux ? (use2 ? p2_latch : p1_latch) :
                            (is_gang & p1_latch);
  wire logic       lead   = use2 ? p2_lead : p1_lead;
  wire logic [7:0] yb     = p1_bus[11:4];
  wire logic [7:0] mid    = {p1_bus[3:0], p2_bus[11:8]};
  wire logic [7:0] lowb   = p2_bus[7:0];

  // a leading hsync edge restarts the group at its first word
  assign slot_cur  = lead ? VIU_SLOT_CB : slot_reg;
  assign slot_next = cap ? viu_advance(slot_cur, is_mux) : slot_cur;

  // group end: fourth byte, or second capture of a 24-bit pair
  wire logic end_grp = cap && (is_mux ? (slot_cur == VIU_SLOT_Y1) :
                               (is_pair && slot_cur == VIU_SLOT_CR));
  // ones, zero, zero must precede (ones, zero in format 7); a stray byte never updates status
  wire logic pre_ok  = (a_reg == `VIU_CODE_ONES) && (y0_reg == `VIU_CODE_ZERO);
  wire logic third0  = is_mux ? (c_reg == `VIU_CODE_ZERO) :
                       fmt6 ? (mid == `VIU_CODE_ZERO) : 1'b1;
  wire logic code_hit = end_grp && pre_ok && third0;
  wire logic [7:0] stat = is_mux ? mbyte : yb;

  // ==========================================================
  // pixel assembly, out order {Y,Cr,Cb}
  wire logic [23:0] pix0 = is_mux ? {y0_reg, c_reg, a_reg} :
                           fmt6   ? {y0_reg, mid, a_reg} :
                                    {y0_reg, a_reg, c_reg};
  wire logic [23:0] pix1 = is_mux ? {mbyte, c_reg, a_reg} :
                           fmt6   ? {yb, mid, a_reg} :
                                    {yb, mid, lowb};
  wire logic        emit0     = end_grp && !code_hit;
  wire logic        emit_one  = cap && single;
  wire logic        valid_next = emit0 | emit_one | pend_reg;
  wire logic [23:0] data_next  = pend_reg ? pend_data_reg :
                                 emit0    ? pix0 : {p1_bus, p2_bus};

  // ==========================================================
  // register port decode
  wire logic        cfg_hit  = (reg_addr == `VIU_CFG_OFS);
  wire logic        stat_hit = (reg_addr == `VIU_STAT_OFS);
  wire logic [31:0] stat_word = {27'h0000000, (kind == VIU_KIND_NONE), mismatch,
                                 htype_reg, vblank_reg, field_reg};
  wire logic [31:0] rdata_next = !reg_rd  ? 32'h0000_0000 :
                                 cfg_hit  ? cfg_reg :
                                 stat_hit ? stat_word : 32'h0000_0000;

  // control register; undefined bits are dropped on write
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_reg   <= `VIU_CFG_RESET;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (reg_wr && cfg_hit) begin
        cfg_reg <= reg_wdata & `VIU_CFG_MASK;
      end
      reg_rdata <= rdata_next;
    end
  end

  // slot tracking and byte holding
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      slot_reg <= VIU_SLOT_CB;
      a_reg    <= 8'h00;
      y0_reg   <= 8'h00;
      c_reg    <= 8'h00;
    end else begin
      slot_reg <= slot_next;
      if (cap && is_mux && slot_cur == VIU_SLOT_CB) a_reg  <= mbyte;
      if (cap && is_mux && slot_cur == VIU_SLOT_Y0) y0_reg <= mbyte;
      if (cap && is_mux && slot_cur == VIU_SLOT_CR) c_reg  <= mbyte;
      if (cap && is_pair && slot_cur == VIU_SLOT_CB) begin
        a_reg  <= mid;
        y0_reg <= yb;
        c_reg  <= lowb;
      end
    end
  end

  // decoded sync; only bits 6..4 of the status byte are used
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      field_reg  <= 1'b0;
      vblank_reg <= 1'b0;
      htype_reg  <= 1'b0;
      sync_eav   <= 1'b0;
      sync_sav   <= 1'b0;
    end else begin
      if (code_hit) begin
        field_reg  <= stat[`VIU_CODE_FIELD];
        vblank_reg <= stat[`VIU_CODE_VBLANK];
        htype_reg  <= stat[`VIU_CODE_HTYPE];
      end
      sync_eav <= code_hit & stat[`VIU_CODE_HTYPE];
      sync_sav <= code_hit & ~stat[`VIU_CODE_HTYPE];
    end
  end

  // pixel output; second pixel of a pair follows one cycle later
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pend_reg      <= 1'b0;
      pend_data_reg <= 24'h000000;
      pix_valid     <= 1'b0;
      pix_data      <= 24'h000000;
      pix_hsync     <= 1'b0;
      pix_vsync     <= 1'b0;
      pix_de        <= 1'b0;
    end else begin
      pend_reg      <= emit0;
      pend_data_reg <= pix1;
      pix_valid     <= valid_next;
      pix_data      <= data_next;
      pix_hsync     <= use2 ? p2_hs : p1_hs;
      pix_vsync     <= use2 ? p2_vs : p1_vs;
      pix_de        <= use2 ? p2_de : p1_de;
    end
  end

  assign pix_field  = field_reg;
  assign pix_vblank = vblank_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_field;
    code_hit |=> (pix_field == $past(stat[6])) && (pix_vblank == $past(stat[5]));
  endproperty
  a_field: assert property (p_field) else $error("field or vblank not taken");

  property p_vblank_hold;
    !code_hit |=> $stable(pix_vblank) && $stable(pix_field);
  endproperty
  a_vblank_hold: assert property (p_vblank_hold) else $error("sync changed");

  property p_htype;
    code_hit |=> (sync_eav == $past(stat[4])) && (sync_sav != sync_eav);
  endproperty
  a_htype: assert property (p_htype) else $error("eav/sav wrong");

  property p_ignore;
    (code_hit && stat[6:4] == 3'b000) |=> !pix_field && !pix_vblank && sync_sav;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored bits leaked");

  property p_preamble;
    code_hit |-> a_reg == 8'hff && y0_reg == 8'h00 && (!is_mux || c_reg == 8'h00);
  endproperty
  a_preamble: assert property (p_preamble) else $error("code without preamble");

  property p_mux_pair;
    (emit0 && is_mux) |=> pix_valid ##1 (pix_valid && pix_data[15:0] == {c_reg, a_reg});
  endproperty
  a_mux_pair: assert property (p_mux_pair) else $error("pixel pair lost");

  property p_lead;
    (lead && !cap) |=> slot_reg == VIU_SLOT_CB;
  endproperty
  a_lead: assert property (p_lead) else $error("hsync did not realign");

  property p_mismatch;
    mismatch |-> !cap ##1 !(pix_valid && !$past(pend_reg));
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("capture on bad format");

  property p_rgb;
    (cap && single) |=> pix_valid && pix_data == $past({p1_bus, p2_bus});
  endproperty
  a_rgb: assert property (p_rgb) else $error("24-bit pixel wrong");

  property p_code_no_pix;
    code_hit |=> !pix_valid ##1 !pix_valid;
  endproperty
  a_code_no_pix: assert property (p_code_no_pix) else $error("code emitted");

  c_mux_code:  cover property (code_hit && is_mux);
  c_ycc16:     cover property (emit0 && fmt6);
  c_rgb24:     cover property (cap && single);
  c_eav:       cover property (sync_eav);

endmodule // viu_unpack

`default_nettype wire

/* verification/viu_gfx_model.sv */
`default_nettype none

module viu_gfx_model (
  input  wire logic        mclk,    // pacing clock
  output logic      [11:0] p1_bus,  // port 1 data
  output logic      [11:0] p2_bus,  // port 2 data
  output logic             pclk,    // pixel clock, both ports
  output logic             hs,      // hsync, both ports
  output logic             vs,      // vsync, both ports
  output logic             de       // data enable, both ports
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // idle: clock stands low outside lines
  initial begin
    p1_bus = 12'h000;
    p2_bus = 12'h000;
    pclk   = 1'b0;
    hs     = 1'b0;
    vs     = 1'b0;
    de     = 1'b0;
  end

  // ==========================================================
  // line start: blank levels while hsync pulses, clock still
  task automatic line_start(input logic [11:0] b1, input logic [11:0] b2);
    @(posedge mclk);
    p1_bus <= b1;
    p2_bus <= b2;
    de     <= 1'b0;
    hs     <= 1'b1;
    vs     <= ~vs;
    repeat (8) @(posedge mclk);
    hs     <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  // one word per clock period; data held around both edges so either
  // latch edge finds it settled, traded against a slow word rate
  task automatic word(input logic [11:0] a, input logic [11:0] b);
    @(posedge mclk);
    p1_bus <= a;
    p2_bus <= b;
    de     <= 1'b1;
    repeat (4) @(posedge mclk);
    pclk   <= 1'b1;
    repeat (8) @(posedge mclk);
    pclk   <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule // viu_gfx_model

`default_nettype wire

/* verification/testbench.sv */
`default_nettype none
`include "viu_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic             mclk, reset, reg_wr, reg_rd, on_p2;
  logic      [7:0]  reg_addr;
  logic      [31:0] reg_wdata;
  wire logic [31:0] reg_rdata;
  wire logic [11:0] p1_bus, p2_bus;
  wire logic        pclk, hs, vs, de, pix_valid, pix_hsync, pix_vsync, pix_de;
  wire logic        pix_field, pix_vblank, sync_eav, sync_sav;
  wire logic [23:0] pix_data;
  integer           seed;
  int               n_mismatch, cmp_count, n_eav, n_sav, exp_eav, exp_sav;
  logic      [23:0] exp_q[$];
  logic      [2:0]  fvh;
  logic      [11:0] tim_hist = 12'h000;
  logic      [31:0] gcfg[6] = '{32'h55, 32'h1055, 32'h66, 32'h77, 32'h88, 32'h99};

  // port 2 timing wired to port 1 timing, as the controller must when ganged
  viu_unpack uut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port1_pixel_bus(p1_bus),
    .port1_hsync(hs), .port1_vsync(vs), .port1_data_enable(de), .port1_pixel_clock(pclk),
    .port2_pixel_bus(p2_bus), .port2_hsync(hs), .port2_vsync(vs),
    .port2_data_enable(de), .port2_pixel_clock(pclk), .pix_valid(pix_valid),
    .pix_data(pix_data), .pix_hsync(pix_hsync), .pix_vsync(pix_vsync), .pix_de(pix_de),
    .pix_field(pix_field), .pix_vblank(pix_vblank), .sync_eav(sync_eav), .sync_sav(sync_sav));
  viu_gfx_model gfx (.mclk(mclk), .p1_bus(p1_bus), .p2_bus(p2_bus), .pclk(pclk), .hs(hs),
    .vs(vs), .de(de));

  // ==========================================================
  // clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(posedge mclk);
    chk(what, reg_rdata, exp);
  endtask

  // one multiplexed byte on the low bits of the chosen port, upper bits random
  task automatic mux_byte(input logic [7:0] b);
    logic [11:0] r;
    r = 12'(rnd());
    if (on_p2) gfx.word(r, {r[11:8], b});
    else gfx.word({r[11:8], b}, r);
  endtask

  // group Cb, Y0, Cr, Y1 from {y1, cr, y0, cb}; two pixels expected
  // expectations go in first: the pixels leave before the last word ends
  task automatic pix_group(input logic [31:0] g);
    exp_q.push_back({g[15:8], g[23:16], g[7:0]});
    exp_q.push_back({g[31:24], g[23:16], g[7:0]});
    mux_byte(g[7:0]);
    mux_byte(g[15:8]);
    mux_byte(g[23:16]);
    mux_byte(g[31:24]);
  endtask

  task automatic drain(input string name);
    for (int i = 0; i < 64 && exp_q.size() != 0; i++) @(posedge mclk);
    chk("pixels_left", exp_q.size(), 32'h0);
    $display("test %s done", name);
    if (exp_q.size() != 0) test_done();
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // reference: every output pixel against the queue, sync pulses counted
  always @(posedge mclk) begin
    if (pix_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("pix_unexpected", {8'h01, pix_data}, 32'h0);
      else chk("pix_data", pix_data, exp_q.pop_front());
    end
    // timing outputs trail the pins by the sync and output stages
    if (reset === 1'b0) chk("pix_timing", {pix_hsync, pix_vsync, pix_de}, tim_hist[11:9]);
    tim_hist <= {tim_hist[8:0], hs, vs, de};
    if (sync_eav === 1'b1) n_eav++;
    if (sync_sav === 1'b1) n_sav++;
  end

  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge mclk);
    chk("watchdog", 32'h1, 32'h0);
    test_done();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [7:0]  st;
    seed = 16725;
    {n_mismatch, cmp_count, n_eav, n_sav, exp_eav, exp_sav} = '0;
    {reset, reg_wr, reg_rd, on_p2, reg_addr, reg_wdata} = '1;
    {reg_wr, reg_rd, on_p2} = '0;
    fvh = 3'h0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rd_chk("cfg_reset", `VIU_CFG_OFS, `VIU_CFG_RESET);
    rd_chk("stat_reset", `VIU_STAT_OFS, 32'h0);
    wr(8'h08, 32'hffff_ffff);
    rd_chk("unmapped", 8'h08, 32'h0);
    wr(`VIU_CFG_OFS, 32'hffff_ffff);
    rd_chk("cfg_mask", `VIU_CFG_OFS, `VIU_CFG_MASK);
    // multiplexed: port 1 rising, port 1 falling, port 2 rising
    for (int p = 0; p < 3; p++) begin
      on_p2 = (p == 2);
      wr(`VIU_CFG_OFS, (p == 1) ? 32'h144 : (p == 2) ? 32'h2044 : 32'h44);
      gfx.line_start(12'h010, 12'h010);
      mux_byte(8'h5a);
      mux_byte(8'ha5);
      gfx.line_start(12'h080, 12'h080);
      pix_group(rnd());
      pix_group(32'h0000ff10);
      for (int s = 0; s < 8; s++) begin
        r  = rnd();
        st = {r[7], s[2:0], r[3:0]};
        mux_byte(8'hff);
        mux_byte(8'h00);
        mux_byte(8'h00);
        mux_byte(st);
        if (st[4]) exp_eav++;
        else exp_sav++;
        fvh = {st[4], st[5], st[6]};
        rd_chk("stat_code", `VIU_STAT_OFS, {29'h0, fvh});
        chk("pix_field", pix_field, st[6]);
        chk("pix_vblank", pix_vblank, st[5]);
        chk("eav_count", n_eav, exp_eav);
        chk("sav_count", n_sav, exp_sav);
        pix_group(rnd());
      end
      pix_group({rnd() & 32'hff00_0000} | 32'h0001_00ff);
      drain("multiplexed");
    end
    // ganged formats, both selectors equal
    for (int k = 0; k < 6; k++) begin
      wr(`VIU_CFG_OFS, gcfg[k]);
      rd_chk("stat_gang", `VIU_STAT_OFS, {29'h0, fvh});
      gfx.line_start(gcfg[k][1] ? 12'h108 : 12'h000, gcfg[k][1] ? 12'h080 : 12'h000);
      for (int s = 0; s < 4; s++) begin
        r = rnd();
        if (gcfg[k][3:0] == 4'h6) begin
          exp_q.push_back({r[7:0], r[31:24], r[23:16]});
          exp_q.push_back({r[15:8], r[31:24], r[23:16]});
          gfx.word({r[7:0], r[23:20]}, {r[19:16], r[7:0]});
          gfx.word({r[15:8], r[31:28]}, {r[27:24], r[15:8]});
        end else begin
          exp_q.push_back(r[23:0]);
          gfx.word(r[23:12], r[11:0]);
        end
      end
      drain("ganged");
    end
    // selectors differ, then an unsupported code: no pixels at all
    wr(`VIU_CFG_OFS, 32'h65);
    rd_chk("stat_mismatch", `VIU_STAT_OFS, {27'h3, fvh});
    gfx.word(12'(rnd()), 12'(rnd()));
    wr(`VIU_CFG_OFS, 32'h22);
    rd_chk("stat_badfmt", `VIU_STAT_OFS, {27'h2, fvh});
    gfx.word(12'(rnd()), 12'(rnd()));
    drain("refused");
    test_done();
  end
endmodule // testbench

`default_nettype wire
